// >>> pcm_pkg.sv
// Package: register map, field layout and reset values of the chop clock and master duty block
package pcm_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] PCM_OFF_CHOP = 12'h000;
  localparam logic [11:0] PCM_OFF_MDC  = 12'h004;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int unsigned PCM_EN_BIT  = 15;
  localparam int unsigned PCM_DIV_W   = 10;
  localparam int unsigned PCM_REG_W   = 16;
  localparam int unsigned PCM_PRE_W   = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic                 PCM_EN_RST   = 1'b0;
  localparam logic [PCM_DIV_W-1:0] PCM_DIV_RST  = 10'h000;
  localparam logic [PCM_REG_W-1:0] PCM_MDC_RST  = 16'h0000;
  localparam logic [31:0]          PCM_ZERO_32  = 32'h0000_0000;

endpackage : pcm_pkg

// >>> pcm_divider.sv
// Programmable counter that turns an input enable pulse stream into a slower pulse stream
module pcm_divider
  import pcm_pkg::*;
#(
  parameter int unsigned WIDTH = 10
) (
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic             run_i,
  input  wire logic             tick_i,
  input  wire logic [WIDTH-1:0] divisor_i,
  output logic                  pulse_o
);

  // Counter and compare are sized for at most sixteen bits
  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("pcm_divider: WIDTH out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             pulse;
  } pcm_div_state_t;

  pcm_div_state_t state;
  pcm_div_state_t next_state;

  // Count input ticks, emit one pulse every divisor+1 ticks
  always_comb begin
    next_state       = state;
    next_state.pulse = 1'b0;
    if (!run_i) begin
      next_state.count = '0;
    end else if (tick_i) begin
      if (state.count >= divisor_i) begin // Also recovers if divisor shrinks mid-count
        next_state.count = '0;
        next_state.pulse = 1'b1;
      end else begin
        next_state.count = state.count + 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pulse_o = state.pulse;

endmodule // pcm_divider

// >>> pcm_chop_mdc.sv
// Top: APB registers for chop clock control and master duty, plus chop clock generation

// ****************************************
// Chop clock and master duty block
// ****************************************
// How it works
// R1: Chop generator runs only while enable bit 15 is set; otherwise it is held.
// R2: Chop rate is clock / prescale / (divider + 1).
// R3: Master duty is a full 16-bit read/write value read back as written.
// R4: Master duty clears to zero at reset.
// R5: Chop bits 14..10 read zero, ignore writes; enable and divider clear at reset.
module pcm_chop_mdc
  import pcm_pkg::*;
#(
  parameter int unsigned DIV_W = PCM_DIV_W
) (
  input  wire logic                 clock_i,
  input  wire logic                 resetn_i,
  // Prescale select comes from logic on this clock, so it passes no synchroniser
  input  wire logic [PCM_PRE_W-1:0] pwm_prescale_select_i,
  // APB slave; only byte lanes 0 and 1 carry register bits
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Chop and duty outputs, each straight from a state flip-flop
  output logic                      chop_clock_o,
  output logic                      chop_tick_o,
  output logic      [PCM_REG_W-1:0] master_duty_o,
  output logic                      chop_generator_enable_o
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Bus byte lane and prescale counter widths the logic below is written for
  localparam int unsigned LANE_W    = 8;
  localparam int unsigned PRE_CNT_W = 8;

  // The read image and the lane split assume the divider field as laid out
  if (DIV_W != PCM_DIV_W) begin : g_bad_div_w
    $error("pcm_chop_mdc: DIV_W must match the chop divider field");
  end
  // Divider must reach into lane 1 yet stay below the enable bit
  if (DIV_W <= LANE_W || DIV_W > PCM_EN_BIT) begin : g_bad_div_span
    $error("pcm_chop_mdc: divider field must straddle the byte lanes below the enable bit");
  end
  // Registers are two byte lanes wide and hold the enable bit
  if (PCM_REG_W != 2 * LANE_W || PCM_EN_BIT >= PCM_REG_W) begin : g_bad_reg_w
    $error("pcm_chop_mdc: register width must be two byte lanes holding the enable bit");
  end
  // The largest prescale ratio must still fit the prescale counter
  if ((1 << PCM_PRE_W) - 1 >= PRE_CNT_W) begin : g_bad_pre_w
    $error("pcm_chop_mdc: prescale select wider than the prescale counter can serve");
  end
  // The two words need distinct, word-aligned byte addresses
  if (PCM_OFF_CHOP[1:0] != 2'b00 || PCM_OFF_MDC[1:0] != 2'b00 || PCM_OFF_CHOP == PCM_OFF_MDC) begin : g_bad_map
    $error("pcm_chop_mdc: register offsets must be distinct aligned words");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                 chop_generator_enable;
    logic [DIV_W-1:0]     chop_divider_value;
    logic [PCM_REG_W-1:0] master_duty;
    logic [7:0]           pre_count;
    logic                 pre_tick;
    logic                 chop_clock;
    logic                 chop_tick;
    logic [31:0]          rdata;
    logic                 ready;
    logic                 slverr;
  } pcm_state_t;

  // Registered state, plus the divider pulse that feeds it
  pcm_state_t state;
  pcm_state_t next_state;
  logic       chop_pulse;

  // ****************************************
  // Chop rate
  // ****************************************
  // Two cascaded enables: pre_tick every 2**select cycles, then a divider pulse
  // every divider+1 of those. Both stages are registered, so the first tick after
  // enabling lags by a couple of cycles; the spacing of later ticks is exact.
  // A divider rewritten while running acts at the next prescaled tick: a count
  // already past the new value ends the period there rather than wrapping.
  // Nothing counts while the enable is low, so every restart begins a full period.
  // Prescale ratio is 2**select; one-cycle enable pulses keep a single clock domain
  logic [7:0] pre_limit;
  assign pre_limit = 8'(({7'h00, 1'b1} << pwm_prescale_select_i) - 8'h01);

  // Chop divider: counts prescaled ticks
  pcm_divider #(
    .WIDTH (DIV_W)
  ) u_div (
    .clock_i   (clock_i),
    .resetn_i  (resetn_i),
    .run_i     (state.chop_generator_enable),     // R1
    .tick_i    (state.pre_tick),                  // R2
    .divisor_i (state.chop_divider_value),        // R2
    .pulse_o   (chop_pulse)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  // Full address compare so that aliases of the two words answer as unmapped
  // pready follows every setup by one cycle: no wait states, ever
  logic setup_ok;
  logic access_done;
  logic is_chop;
  logic is_mdc;
  logic is_mapped;
  assign setup_ok    = psel && !penable;
  assign access_done = psel && penable && state.ready; // Completing edge only
  assign is_chop     = (paddr == PCM_OFF_CHOP);
  assign is_mdc      = (paddr == PCM_OFF_MDC);
  assign is_mapped   = is_chop || is_mdc;

  // ****************************************
  // Next state
  // ****************************************
  // Single next-state process; pulses default low so each lasts one cycle
  always_comb begin
    next_state           = state;
    next_state.ready     = 1'b0;
    next_state.slverr    = 1'b0;
    next_state.pre_tick  = 1'b0;
    // Gated by the enable so a pulse already inside the divider cannot leak out after a stop
    next_state.chop_tick = chop_pulse && state.chop_generator_enable; // R1

    // Prescaler stopped while disabled so the first chop period is full length
    if (!state.chop_generator_enable) begin // R1
      next_state.pre_count  = '0;
      next_state.chop_clock = 1'b0;
    end else begin
      if (state.pre_count >= pre_limit) begin // R2
        next_state.pre_count = '0;
        next_state.pre_tick  = 1'b1;
      end else begin
        next_state.pre_count = state.pre_count + 8'h01;
      end
      // Square wave for consumers that want a level rather than a strobe
      if (chop_pulse) begin
        next_state.chop_clock = ~state.chop_clock; // Toggle per divided tick
      end
    end

    // APB: answer decided in setup, pready high in the access cycle
    if (setup_ok) begin
      next_state.ready  = 1'b1;
      next_state.slverr = !is_mapped; // Unmapped: error, zero data, no write
      next_state.rdata  = PCM_ZERO_32;
      // Read data captured in setup, so it stands through the access cycle
      if (!pwrite) begin
        if (is_chop) begin
          next_state.rdata[PCM_EN_BIT]    = state.chop_generator_enable; // R5
          next_state.rdata[DIV_W-1:0]     = state.chop_divider_value;
        end else if (is_mdc) begin
          next_state.rdata[PCM_REG_W-1:0] = state.master_duty; // R3
        end
      end
    end

    // Write takes effect at the completing edge only
    if (access_done && pwrite) begin
      if (is_chop) begin
        // Lane 1 holds the enable and the top of the divider, lane 0 the rest
        if (pstrb[1]) begin
          next_state.chop_generator_enable = pwdata[PCM_EN_BIT]; // R1 R5
          next_state.chop_divider_value[DIV_W-1:8] = pwdata[DIV_W-1:8];
        end
        if (pstrb[0]) begin
          next_state.chop_divider_value[7:0] = pwdata[7:0]; // R2
        end
      end else if (is_mdc) begin
        // Each lane of the duty word is written on its own strobe
        if (pstrb[1]) begin
          next_state.master_duty[15:8] = pwdata[15:8]; // R3
        end
        if (pstrb[0]) begin
          next_state.master_duty[7:0] = pwdata[7:0]; // R3
        end
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Asynchronous clear; the field resets spell out the power-on values
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state                       <= '0;
      state.chop_generator_enable <= PCM_EN_RST;  // R5
      state.chop_divider_value    <= PCM_DIV_RST; // R5
      state.master_duty           <= PCM_MDC_RST; // R4
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output is a state flip-flop, never a decode
  assign prdata                  = state.rdata;
  assign pready                  = state.ready;
  assign pslverr                 = state.slverr;
  assign chop_clock_o            = state.chop_clock;
  assign chop_tick_o             = state.chop_tick;
  assign master_duty_o           = state.master_duty;
  assign chop_generator_enable_o = state.chop_generator_enable;

endmodule // pcm_chop_mdc

// >>> pcm_chop_mdc_checker.sv
// Checker: concurrent properties of the chop clock and master duty block
module pcm_chk
  import pcm_pkg::*;
(
  input wire logic                 clock_i,
  input wire logic                 resetn_i,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [3:0]           pstrb,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 chop_tick_o,
  input wire logic [PCM_REG_W-1:0] master_duty_o,
  input wire logic                 chop_generator_enable_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // Completed access phase
  wire acc = psel && penable && pready;
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no answer after setup");
  property p_mdc_wr; acc && pwrite && paddr == PCM_OFF_MDC && pstrb == 4'hf |=> master_duty_o == 16'($past(pwdata));
  endproperty
  a_mdc_wr: assert property (p_mdc_wr) else $error("duty not stored");
  property p_mdc_rd; acc && !pwrite && paddr == PCM_OFF_MDC |-> prdata == {16'h0000, master_duty_o}; endproperty
  a_mdc_rd: assert property (p_mdc_rd) else $error("duty readback wrong");
  property p_chop_rd; acc && !pwrite && paddr == PCM_OFF_CHOP |-> prdata[31:10] == {16'h0000, chop_generator_enable_o, 5'h00};
  endproperty
  a_chop_rd: assert property (p_chop_rd) else $error("chop upper bits wrong");
  // Held generator must stay silent
  property p_off; !chop_generator_enable_o && $past(!chop_generator_enable_o) |-> !chop_tick_o; endproperty
  a_off: assert property (p_off) else $error("tick while disabled");
  property p_rst; @(posedge clock_i) disable iff (1'b0) !resetn_i |-> master_duty_o == 16'h0000 && !chop_generator_enable_o;
  endproperty
  a_rst: assert property (p_rst) else $error("state not cleared in reset");
endmodule // pcm_chk
bind pcm_chop_mdc pcm_chk chk_u (.clock_i(clock_i), .resetn_i(resetn_i), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .chop_tick_o(chop_tick_o),
  .master_duty_o(master_duty_o), .chop_generator_enable_o(chop_generator_enable_o));

// >>> tb_top.sv
// Testbench: APB register and chop rate scenarios for the chop clock and master duty block
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; $display("Error %0t: got %h exp %h", $time, a, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pcm_pkg::*;
  logic        clock_i = 0, resetn_i, psel = 0, penable = 0, pwrite = 0, err;
  logic [2:0]  sel = 3'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, chop_clock_o, chop_tick_o, en;
  logic [15:0] duty;
  int          fails = 0, samples_checked = 0;
  pcm_chop_mdc dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .pwm_prescale_select_i(sel), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chop_clock_o(chop_clock_o), .chop_tick_o(chop_tick_o),
    .master_duty_o(duty), .chop_generator_enable_o(en));
  initial forever #5 clock_i = ~clock_i;
  task automatic conclude;
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock_i) penable <= 1;
    n = 0;
    do begin @(posedge clock_i); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin fails++; conclude(); end // Bound used up
    r = prdata; err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clock_i);
  endtask
  // Reset values, duty readback, byte lanes, reserved bits, unmapped access
  task automatic regs;
    apb(0, PCM_OFF_MDC, 0); `CHK({err, r}, 33'h0)
    apb(0, PCM_OFF_CHOP, 0); `CHK(r, 32'h0)
    apb(1, PCM_OFF_MDC, 32'hffff_a5c3); apb(0, PCM_OFF_MDC, 0); `CHK(r, 32'h0000_a5c3)
    pstrb <= 4'h1; apb(1, PCM_OFF_MDC, 32'h0000_0011); pstrb <= 4'hf;
    apb(0, PCM_OFF_MDC, 0); `CHK(r, 32'h0000_a511)
    `CHK(duty, 16'ha511)
    apb(1, PCM_OFF_CHOP, 32'hffff_7fff); apb(0, PCM_OFF_CHOP, 0); `CHK(r, 32'h0000_03ff)
    apb(0, 12'h010, 0); `CHK({err, r}, 33'h1_0000_0000)
  endtask
  // Tick spacing must be 2**sel * (div + 1) cycles; the chop clock flips once per tick
  task automatic rate(input logic [2:0] s, input logic [9:0] d);
    int n, g;
    logic c;
    sel <= s;
    apb(1, PCM_OFF_CHOP, {16'h0000, 1'b1, 5'h00, d});
    `CHK(en, 1'b1)
    n = 0;
    do begin @(posedge clock_i); n++; end while (chop_tick_o !== 1'b1 && n < 2000);
    c = chop_clock_o;
    g = 0;
    do begin @(posedge clock_i); g++; end while (chop_tick_o !== 1'b1 && g < 2000);
    if (chop_tick_o !== 1'b1) begin fails++; conclude(); end // Bound used up
    `CHK(g, (1 << s) * (int'(d) + 1))
    `CHK(chop_clock_o, ~c)
  endtask
  // Clearing enable stops ticks and parks the chop clock low
  task automatic stop;
    int t;
    apb(1, PCM_OFF_CHOP, 32'h0000_0003);
    t = 0;
    repeat (60) begin @(posedge clock_i); t += chop_tick_o; end
    `CHK({t[7:0], chop_clock_o}, 9'h0)
  endtask
  // Mid-run reset clears a running enable, the divider and the duty back to zero
  task automatic rerst;
    apb(1, PCM_OFF_CHOP, 32'h0000_8155);
    apb(1, PCM_OFF_MDC, 32'h0000_beef);
    `CHK({en, duty}, 17'h1_beef)
    resetn_i <= 0;
    repeat (3) @(posedge clock_i);
    `CHK({en, duty, chop_tick_o, chop_clock_o}, 19'h0)
    resetn_i <= 1;
    @(posedge clock_i);
    apb(0, PCM_OFF_CHOP, 0);
    `CHK(r, 32'h0)
    apb(0, PCM_OFF_MDC, 0);
    `CHK(r, 32'h0)
  endtask
  initial begin
    resetn_i <= 0;
    repeat (3) @(posedge clock_i);
    resetn_i <= 1;
    @(posedge clock_i);
    regs();
    rate(3'h1, 10'h002);
    rate(3'h0, 10'h004);
    rate(3'h2, 10'h001);
    stop();
    rerst();
    conclude();
  end
endmodule // tb_top
